// file: pkg/sas_consts.svh
// constants of the smoke alarm sequencer: offsets, fields, resets, timing
// Behaviour
// - idle timebase 1.65 s, one smoke check each
// - skip check during led, chirp, horn on
// - battery check every 24 timebase cycles
// - smoke: 41.67 ms period, horn enabled
// - alarm horn 500 ms on, 500 ms off
// - recheck smoke in horn off; clear stops horn
// - alarm ends only in horn off phase
// - local smoke: no battery alarm, led 1 hz
// - remote smoke: led also inhibited
// - local smoke drives the interconnect line
// - line driver off three cycles after reset
// - test low: no strobing, comparator shows smoke
// - each power strobe lasts 10 ms
// - battery judged during led pulse, ~40 s
// - led pulse loads battery 11.6 ms
// - local smoke selects more sensitive threshold
// - comparators strobed at most once per timebase cycle
`ifndef SAS_CONSTS_SVH
`define SAS_CONSTS_SVH

// clock rate and time to cycle conversion
`define SAS_CLK_MHZ 250
`define SAS_US2CYC(t) ((t) * `SAS_CLK_MHZ)

// times in microseconds
`define SAS_T_IDLE_US 1650000
`define SAS_T_SMOKE_US 41670
`define SAS_T_HORN_US 500000
`define SAS_T_STROBE_US 10000
`define SAS_T_LED_US 11600
`define SAS_T_CHIRP_US 11600

// counts in timebase cycles
`define SAS_BAT_EVERY 5'h18
`define SAS_IO_HOLD 2'h3

// register word offsets
`define SAS_REG_CTRL 8'h00
`define SAS_REG_STATUS 8'h04
`define SAS_REG_ISTAT 8'h08
`define SAS_REG_IMASK 8'h0c

// field positions
`define SAS_CTRL_TEST 0
`define SAS_IRQ_SMOKE 0
`define SAS_IRQ_CLEAR 1
`define SAS_IRQ_REMOTE 2
`define SAS_IRQ_LOWBAT 3

// reset values
`define SAS_CTRL_RST 1'h0
`define SAS_MASK_RST 4'h0
`define SAS_PIN_RST 4'h4

`endif

// file: pkg/sas_pkg.sv
// types of the smoke alarm sequencer
package sas_pkg;
  // alarm condition
  typedef enum logic [1:0] {
    sas_st_idle,
    sas_st_local,
    sas_st_remote
  } sas_state_t;
  // counter word for long timers
  typedef logic [31:0] sas_cnt_t;
  // interrupt event vector
  typedef logic [3:0] sas_irq_t;
endpackage

// file: pkg/sas_tb_if.sv
// link between the sequencer and its timebase divider
`timescale 1ns/10ps
interface sas_tb_if;
  logic fast; // select smoke period
  logic tick; // one-cycle end of timebase cycle
  modport gen(input fast, output tick);
  modport user(output fast, input tick);
endinterface

// file: src/sas_timebase.sv
// timebase divider with idle and smoke periods
`timescale 1ns/10ps
`include "sas_consts.svh"
module sas_timebase
  import sas_pkg::*;
#(
  parameter sas_cnt_t IDLE_CYC = 32'(`SAS_US2CYC(`SAS_T_IDLE_US)),
  parameter sas_cnt_t SMOKE_CYC = 32'(`SAS_US2CYC(`SAS_T_SMOKE_US))
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sequencer side
  sas_tb_if.gen tb
);
  sas_cnt_t cnt_r; // cycles into current period
  sas_cnt_t last; // final count of selected period

  // a switch to the short period with the count past its end wraps at once rather than running on
  assign last = tb.fast ? SMOKE_CYC - 32'h1 : IDLE_CYC - 32'h1;

  // period counter and tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      tb.tick <= 1'b0;
    end else if (cnt_r >= last) begin
      cnt_r <= '0;
      tb.tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tb.tick <= 1'b0;
    end
  end
endmodule

// file: src/sas_seq.sv
// smoke alarm sequencer: strobing, alarm states, horn, led, line, bus
`timescale 1ns/10ps
`include "sas_consts.svh"
module sas_seq
  import sas_pkg::*;
#(
  parameter sas_cnt_t IDLE_CYC = 32'(`SAS_US2CYC(`SAS_T_IDLE_US)),
  parameter sas_cnt_t SMOKE_CYC = 32'(`SAS_US2CYC(`SAS_T_SMOKE_US)),
  parameter sas_cnt_t HORN_CYC = 32'(`SAS_US2CYC(`SAS_T_HORN_US)),
  parameter sas_cnt_t STROBE_CYC = 32'(`SAS_US2CYC(`SAS_T_STROBE_US)),
  parameter sas_cnt_t LED_CYC = 32'(`SAS_US2CYC(`SAS_T_LED_US)),
  parameter sas_cnt_t CHIRP_CYC = 32'(`SAS_US2CYC(`SAS_T_CHIRP_US))
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // comparator and test pins
  input wire logic smoke_cmp_i,
  input wire logic lowbat_cmp_i,
  input wire logic test_n_i,
  // interconnect line
  input wire logic io_i,
  output logic io_o,
  output logic io_oe_o,
  // alarm outputs
  output logic horn_o,
  output logic led_o,
  output logic strobe_o,
  output logic comp_o,
  output logic hyst_o,
  output logic irq_o
);
  localparam logic [3:0] PIN_RST = `SAS_PIN_RST;

  sas_tb_if tb(); // timebase link

  // pin synchronisers
  logic [3:0] pin_raw; // raw pins
  logic [3:0] s1_r, s2_r, s3_r; // three flops per pin
  logic [3:0] pin_f_r; // accepted level
  logic smoke_f, lowbat_f, testn_f, io_f; // filtered pins

  // sequencing state
  sas_state_t state_r, state_nxt; // alarm condition
  logic [1:0] hold_cnt_r; // ticks since reset
  logic [4:0] bat_cnt_r; // ticks toward battery check
  logic strobe_r; // comparator power strobe
  sas_cnt_t strobe_cnt_r; // strobe length counter
  logic led_r; // led pulse running
  logic led_bat_r; // led pulse is a battery check
  sas_cnt_t led_cnt_r; // led pulse counter
  logic chirp_r; // low battery chirp running
  sas_cnt_t chirp_cnt_r; // chirp counter
  logic ph_on_r; // horn modulation on phase
  sas_cnt_t ph_cnt_r; // modulation phase counter
  logic smoke_r; // last strobed smoke result
  logic [4:0] oe_hist_r; // recent own line drive

  // bus registers
  logic ack_r; // bus acknowledge
  logic [31:0] dat_r; // read data
  logic ctrl_test_r; // software forced test mode
  sas_irq_t istat_r; // sticky interrupt status
  sas_irq_t imask_r; // interrupt mask

  // decoded terms
  logic test, alarm, io_ready, skip;
  logic strobe_end, sample_ev, led_end, chirp_start;
  logic ph_wrap, alarm_enter, ph_start, led_start;
  logic bat_due;
  logic wb_hit, wb_wr;
  sas_irq_t ev, clr;

  assign pin_raw = {io_i, test_n_i, lowbat_cmp_i, smoke_cmp_i};

  // three flops per pin; a change counts once the last two agree
  genvar g;
  for (g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_r[g] <= PIN_RST[g];
        s2_r[g] <= PIN_RST[g];
        s3_r[g] <= PIN_RST[g];
        pin_f_r[g] <= PIN_RST[g];
      end else begin
        s1_r[g] <= pin_raw[g];
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        if (s2_r[g] == s3_r[g]) begin
          pin_f_r[g] <= s3_r[g];
        end
      end
    end
  end

  assign smoke_f = pin_f_r[0];
  assign lowbat_f = pin_f_r[1];
  assign testn_f = pin_f_r[2];
  assign io_f = pin_f_r[3];

  // test mode from the pin or from software
  assign test = ~testn_f | ctrl_test_r;
  assign alarm = (state_r != sas_st_idle);
  assign io_ready = (hold_cnt_r == `SAS_IO_HOLD);
  // no check while led, chirp or horn burst is busy
  assign skip = led_r | chirp_r | (alarm & ph_on_r);
  assign strobe_end = strobe_r & (strobe_cnt_r == STROBE_CYC - 32'h1);
  // in test mode the comparators are read every cycle
  assign sample_ev = test | strobe_end;
  assign led_end = led_r & (led_cnt_r == LED_CYC - 32'h1);
  assign bat_due = tb.tick & (state_r == sas_st_idle) & (bat_cnt_r == `SAS_BAT_EVERY - 5'h1);
  // chirp only for a failed check with no alarm running
  assign chirp_start = led_end & led_bat_r & lowbat_f & (state_r == sas_st_idle)
                       & (state_nxt == sas_st_idle);
  assign ph_wrap = alarm & (ph_cnt_r == HORN_CYC - 32'h1);
  assign alarm_enter = ~alarm & (state_nxt != sas_st_idle);
  assign ph_start = alarm_enter | (ph_wrap & ~ph_on_r);
  // led at each on phase gives one pulse per second in local smoke
  // a battery pulse racing into remote smoke is dropped, not started
  assign led_start = (ph_start & (state_nxt == sas_st_local))
                     | (bat_due & (state_nxt == sas_st_idle));

  // timebase runs fast whenever an alarm is sounding
  assign tb.fast = alarm;

  sas_timebase #(
    .IDLE_CYC(IDLE_CYC),
    .SMOKE_CYC(SMOKE_CYC)
  ) u_tb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tb(tb)
  );

  // alarm condition transitions
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sas_st_idle: begin
        if (sample_ev & smoke_f) begin
          state_nxt = sas_st_local;
        end else if (io_f & (oe_hist_r == 5'h0)) begin
          state_nxt = sas_st_remote;
        end
      end
      sas_st_local: begin
        // smoke gone: leave only while horn is silent
        if (sample_ev & ~smoke_f & ~ph_on_r) begin
          state_nxt = sas_st_idle;
        end
      end
      sas_st_remote: begin
        if (sample_ev & smoke_f) begin
          state_nxt = sas_st_local;
        end else if (~io_f & ~ph_on_r) begin
          state_nxt = sas_st_idle;
        end
      end
      default: state_nxt = sas_st_idle;
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= sas_st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  // driver hold-off after power up, counted in timebase ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_cnt_r <= 2'h0;
    end else if (tb.tick & ~io_ready) begin
      hold_cnt_r <= hold_cnt_r + 2'h1;
    end
  end

  // battery schedule counts idle timebase cycles only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bat_cnt_r <= 5'h0;
    end else if (bat_due) begin
      bat_cnt_r <= 5'h0;
    end else if (tb.tick & (state_r == sas_st_idle)) begin
      bat_cnt_r <= bat_cnt_r + 5'h1;
    end
  end

  // power strobe: one per tick unless busy or in test
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_r <= 1'b0;
      strobe_cnt_r <= '0;
    end else if (test) begin
      strobe_r <= 1'b0;
      strobe_cnt_r <= '0;
    end else if (strobe_end) begin
      strobe_r <= 1'b0;
      strobe_cnt_r <= '0;
    end else if (strobe_r) begin
      strobe_cnt_r <= strobe_cnt_r + 32'h1;
    end else if (tb.tick & ~skip) begin
      strobe_r <= 1'b1;
    end
  end

  // smoke result held between strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smoke_r <= 1'b0;
    end else if (sample_ev) begin
      smoke_r <= smoke_f;
    end
  end

  // led pulse; remote smoke never starts one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_r <= 1'b0;
      led_bat_r <= 1'b0;
      led_cnt_r <= '0;
    end else if (led_end) begin
      led_r <= 1'b0;
      led_bat_r <= 1'b0;
      led_cnt_r <= '0;
    end else if (led_r) begin
      led_cnt_r <= led_cnt_r + 32'h1;
    end else if (led_start) begin
      led_r <= 1'b1;
      led_bat_r <= bat_due;
    end
  end

  // low battery chirp
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chirp_r <= 1'b0;
      chirp_cnt_r <= '0;
    end else if (chirp_r) begin
      if (chirp_cnt_r == CHIRP_CYC - 32'h1) begin
        chirp_r <= 1'b0;
        chirp_cnt_r <= '0;
      end else begin
        chirp_cnt_r <= chirp_cnt_r + 32'h1;
      end
    end else if (chirp_start) begin
      chirp_r <= 1'b1;
    end
  end

  // horn modulation; a burst always runs to its end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_on_r <= 1'b0;
      ph_cnt_r <= '0;
    end else if (alarm_enter) begin
      ph_on_r <= 1'b1;
      ph_cnt_r <= '0;
    end else if (~alarm) begin
      ph_on_r <= 1'b0;
      ph_cnt_r <= '0;
    end else if (ph_wrap) begin
      ph_on_r <= ~ph_on_r;
      ph_cnt_r <= '0;
    end else begin
      ph_cnt_r <= ph_cnt_r + 32'h1;
    end
  end

  // pin outputs, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      horn_o <= 1'b0;
      led_o <= 1'b0;
      strobe_o <= 1'b0;
      comp_o <= 1'b0;
      hyst_o <= 1'b0;
      io_o <= 1'b0;
      io_oe_o <= 1'b0;
      oe_hist_r <= 5'h0;
    end else begin
      horn_o <= (alarm & ph_on_r) | chirp_r;
      led_o <= led_r;
      // strobing bypassed: comparators held powered
      strobe_o <= strobe_r | test;
      comp_o <= test ? smoke_f : smoke_r;
      hyst_o <= (state_r == sas_st_local);
      io_o <= 1'b1;
      io_oe_o <= (state_r == sas_st_local) & io_ready;
      // own drive echoes back through the synchroniser for a few cycles
      oe_hist_r <= {oe_hist_r[3:0], io_oe_o};
    end
  end

  // interrupt events
  always_comb begin
    ev = '0;
    ev[`SAS_IRQ_SMOKE] = (state_nxt == sas_st_local) & (state_r != sas_st_local);
    ev[`SAS_IRQ_CLEAR] = (state_r == sas_st_local) & (state_nxt == sas_st_idle);
    ev[`SAS_IRQ_REMOTE] = (state_r == sas_st_idle) & (state_nxt == sas_st_remote);
    ev[`SAS_IRQ_LOWBAT] = chirp_start;
  end

  // bus decode
  assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_wr = wb_hit & wb_we_i & wb_sel_i[0];
  assign clr = (wb_wr & ({wb_adr_i[7:2], 2'h0} == `SAS_REG_ISTAT)) ? wb_dat_i[3:0] : 4'h0;

  // sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat_r <= '0;
    end else begin
      istat_r <= (istat_r & ~clr) | ev;
    end
  end

  // writable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_test_r <= `SAS_CTRL_RST;
      imask_r <= `SAS_MASK_RST;
    end else if (wb_wr) begin
      case ({wb_adr_i[7:2], 2'h0})
        `SAS_REG_CTRL: ctrl_test_r <= wb_dat_i[`SAS_CTRL_TEST];
        `SAS_REG_IMASK: imask_r <= wb_dat_i[3:0];
        default: ;
      endcase
    end
  end

  // ack one cycle after request, read data with it; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= wb_hit;
      if (wb_hit) begin
        case ({wb_adr_i[7:2], 2'h0})
          `SAS_REG_CTRL: dat_r <= {31'h0, ctrl_test_r};
          `SAS_REG_STATUS: dat_r <= {24'h0, io_ready, lowbat_f, chirp_r, led_r,
                                     ph_on_r, test, state_r};
          `SAS_REG_ISTAT: dat_r <= {28'h0, istat_r};
          `SAS_REG_IMASK: dat_r <= {28'h0, imask_r};
          default: dat_r <= '0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // level interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(istat_r & imask_r);
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence led_run_s;
    led_o [*8];
  endsequence

  sequence alarm_on_s;
    (state_r == sas_st_idle) ##1 (state_r == sas_st_local);
  endsequence

  sas_cnt_t strobe_len_q; // helper: cycles strobe has been high
  always_ff @(posedge clk_i) begin
    if (rst_i | ~strobe_o) begin
      strobe_len_q <= '0;
    end else begin
      strobe_len_q <= strobe_len_q + 32'h1;
    end
  end

  io_holdoff_a: assert property (io_oe_o |-> io_ready)
    else $error("line driven before hold-off");
  io_drive_a: assert property ((state_r == sas_st_local) && io_ready |=> io_oe_o)
    else $error("local smoke did not drive line");
  alarm_exit_a: assert property ($fell(hyst_o) |-> !$past(horn_o))
    else $error("alarm ended during horn burst");
  chirp_inhib_a: assert property ($rose(chirp_r) |-> (state_r == sas_st_idle)
    && ($past(state_r) == sas_st_idle))
    else $error("chirp during alarm");
  led_remote_a: assert property ($rose(led_r) |-> state_r != sas_st_remote)
    else $error("led pulse in remote smoke");
  led_length_a: assert property ($rose(led_o) |-> led_run_s)
    else $error("led pulse too short");
  hyst_follow_a: assert property (alarm_on_s |=> hyst_o)
    else $error("threshold not switched on smoke");
  test_mode_a: assert property (test ##1 test |=> strobe_o && comp_o == $past(smoke_f))
    else $error("test mode not bypassing strobe");
  strobe_len_a: assert property ($fell(strobe_o) && !$past(test, 2)
    |-> $past(strobe_len_q) == STROBE_CYC - 32'h1)
    else $error("strobe length wrong");
  irq_level_a: assert property (##1 irq_o == |($past(istat_r) & $past(imask_r)))
    else $error("interrupt level wrong");
endmodule

// file: testbench/sas_peer.sv
// model of the other units that share the interconnect line
`timescale 1ns/10ps
module sas_peer (
  // clock
  input wire logic clk_i,
  // command from the bench
  input wire logic want_i,
  input wire logic [3:0] lag_i,
  // our own unit's line driver
  input wire logic oe_i,
  input wire logic out_i,
  // resolved line level
  output logic line_o
);
  logic [3:0] cnt_r; // delay before a peer drives
  logic drv_r; // a peer is driving
  // a peer answers after lag cycles; the bench draws a single random lag
  always_ff @(posedge clk_i) begin
    if (!want_i) begin
      cnt_r <= 4'h0;
      drv_r <= 1'b0;
    end else if (cnt_r < lag_i) begin
      cnt_r <= cnt_r + 4'h1;
    end else begin
      drv_r <= 1'b1;
    end
  end
  // the small current sink pulls an undriven line low
  assign line_o = (oe_i & out_i) | drv_r;
endmodule

// file: testbench/tb.sv
// self-checking bench of the smoke alarm sequencer
`timescale 1ns/10ps
module tb;
  import sas_pkg::*;
  // shortened timing, all expectations derive from these
  localparam int SB = 10;
  localparam int SM = 100;
  localparam int ID = 200;
  localparam int HN = 300;
  localparam int LD = 12;
  // monitor bit positions
  localparam int HO = 0;
  localparam int LE = 1;
  localparam int ST = 2;
  localparam int CO = 3;
  localparam int HY = 4;
  localparam int OE = 5;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  // bus master signals
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  // pins
  logic smoke = 1'b1;
  logic lowbat = 1'b0;
  logic test_n = 1'b1;
  logic want = 1'b0;
  logic [3:0] lag = 4'h0;
  logic io_line, io_o, io_oe_o, horn_o, led_o, strobe_o, comp_o, hyst_o, irq_o;
  logic [5:0] mon;
  logic [5:0] mq;
  int rc [6]; // rising edges seen per output
  int cyc_n = 0;
  int n_mismatch = 0;
  int compares = 0;
  int n;
  int t0;
  logic [31:0] q;

  always #2 clk_i = ~clk_i;
  assign mon = {io_oe_o, hyst_o, comp_o, strobe_o, led_o, horn_o};
  // count rising edges and cycles for period checks
  always @(posedge clk_i) begin
    for (int i = 0; i < 6; i++) if (mon[i] === 1'b1 && mq[i] !== 1'b1) rc[i]++;
    mq <= mon;
    cyc_n++;
  end

  sas_seq #(.IDLE_CYC(32'(ID)), .SMOKE_CYC(32'(SM)), .HORN_CYC(32'(HN)),
    .STROBE_CYC(32'(SB)), .LED_CYC(32'(LD)), .CHIRP_CYC(32'(LD))) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .smoke_cmp_i(smoke), .lowbat_cmp_i(lowbat), .test_n_i(test_n), .io_i(io_line),
    .io_o(io_o), .io_oe_o(io_oe_o), .horn_o(horn_o), .led_o(led_o),
    .strobe_o(strobe_o), .comp_o(comp_o), .hyst_o(hyst_o), .irq_o(irq_o));

  sas_peer peer_u (.clk_i(clk_i), .want_i(want), .lag_i(lag), .oe_i(io_oe_o),
    .out_i(io_o), .line_o(io_line));

  // verdict and end of run
  task automatic conclude();
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // expected timebase period in cycles for the selected rate
  function automatic int period_of(input logic fast);
    return fast ? SM : ID;
  endfunction

  // wait for an output level, k counts the edges waited; bounded
  task automatic wt(input int b, input logic v, output int k);
    k = 0;
    while (mon[b] !== v) begin
      @(posedge clk_i);
      #1;
      k++;
      if (k > 6000) begin
        chk("wait bound", 32'h0, 32'h1);
        conclude();
      end
    end
  endtask

  // one classic bus cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      chk("bus ack", 32'h1, 32'h0);
      conclude();
    end
  endtask

  initial begin
    void'($urandom(21341));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped word, unmask the smoke event
    wb(1'b0, 8'h00, 32'h0, q);
    chk("ctrl reset", 32'h0, q);
    wb(1'b0, 8'h0c, 32'h0, q);
    chk("imask reset", 32'h0, q);
    wb(1'b0, 8'h10, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    wb(1'b1, 8'h0c, 32'h1, q);
    // smoke from the start: alarm comes before the line hold-off ends
    wt(HY, 1'b1, n);
    chk("line enable in hold-off", 32'h0, {31'h0, io_oe_o});
    wt(OE, 1'b1, n);
    chk("line level", 32'h1, {31'h0, io_line});
    chk("smoke irq", 32'h1, {31'h0, irq_o});
    // horn burst length and no strobe while horn sounds
    wt(HO, 1'b0, n);
    wt(HO, 1'b1, n);
    t0 = rc[ST];
    wt(HO, 1'b0, n);
    chk("horn on", 32'(HN), 32'(n));
    chk("strobes in horn on", 32'h0, 32'(rc[ST] - t0));
    chk("threshold select", 32'h1, {31'h0, hyst_o});
    // fast timebase in horn off phase
    wt(ST, 1'b0, n);
    wt(ST, 1'b1, n);
    t0 = cyc_n;
    wt(ST, 1'b0, n);
    chk("strobe width", 32'(SB), 32'(n));
    wt(ST, 1'b1, n);
    chk("smoke period", 32'(period_of(1'b1)), 32'(cyc_n - t0));
    // led at 1 hz while alarming
    wt(LE, 1'b1, n);
    t0 = cyc_n;
    wt(LE, 1'b0, n);
    chk("led width", 32'(LD), 32'(n));
    wt(LE, 1'b1, n);
    chk("led period", 32'(2 * HN), 32'(cyc_n - t0));
    // clear smoke mid burst: burst completes, alarm ends in off phase
    @(posedge clk_i);
    smoke <= 1'b0;
    wt(HY, 1'b0, n);
    chk("horn at alarm end", 32'h0, {31'h0, horn_o});
    t0 = rc[HO];
    repeat (2 * HN) @(posedge clk_i);
    chk("horn after clear", 32'h0, 32'(rc[HO] - t0));
    // idle strobes one slow period apart
    wt(ST, 1'b0, n);
    wt(ST, 1'b1, n);
    t0 = cyc_n;
    wt(ST, 1'b0, n);
    wt(ST, 1'b1, n);
    chk("idle period", 32'(period_of(1'b0)), 32'(cyc_n - t0));
    // sticky events, write one to clear, irq follows
    wb(1'b0, 8'h08, 32'h0, q);
    chk("events", 32'h3, q & 32'hf);
    wb(1'b1, 8'h08, 32'h3, q);
    wb(1'b0, 8'h08, 32'h0, q);
    chk("events cleared", 32'h0, q & 32'hf);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    // another unit raises the line after a random lag
    @(posedge clk_i);
    lag <= 4'($urandom);
    want <= 1'b1;
    wt(HO, 1'b1, n);
    chk("remote is not local", 32'h0, {31'h0, hyst_o});
    t0 = rc[LE];
    repeat (2 * HN) @(posedge clk_i);
    chk("led in remote", 32'h0, 32'(rc[LE] - t0));
    @(posedge clk_i);
    want <= 1'b0;
    repeat (3 * HN) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("remote ended", 32'h0, q & 32'h3);
    // test pin: strobing bypassed, comparator output follows smoke
    @(posedge clk_i);
    test_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("strobe in test", 32'h1, {31'h0, strobe_o});
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      smoke <= 1'($urandom);
      repeat (8) @(posedge clk_i);
      chk("comparator output", {31'h0, smoke}, {31'h0, comp_o});
    end
    @(posedge clk_i);
    smoke <= 1'b0;
    test_n <= 1'b1;
    // test mode forced by register instead of pin
    wb(1'b1, 8'h00, 32'h1, q);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("register test mode", 32'h4, q & 32'h4);
    wb(1'b1, 8'h00, 32'h0, q);
    wt(HY, 1'b0, n);
    // low battery: led load, chirp, then next check 24 timebase cycles later
    @(posedge clk_i);
    lowbat <= 1'b1;
    wt(LE, 1'b0, n);
    wt(LE, 1'b1, n);
    t0 = cyc_n;
    wt(LE, 1'b0, n);
    chk("battery load width", 32'(LD), 32'(n));
    wt(HO, 1'b1, n);
    wt(HO, 1'b0, n);
    chk("chirp width", 32'(LD), 32'(n));
    wt(LE, 1'b1, n);
    chk("battery check period", 32'(24 * ID), 32'(cyc_n - t0));
    conclude();
  end
endmodule
